/* File: hdl/tpg_gpio.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"

// Overview of operation
// - three independent eight-pin ports, port 1 to port 3.
// - ports 1 and 2 drive and pull up only when activate bit 0 and function enable bit 1 set.
// - base address comes from two base bytes, low and high.
// - bank select bit 7 picks the visible register bank.
// - port 1 at 0-3 bank0 and 0-2 bank1; port 2 bank0 4-7; port 3 bank1 4-7.
// - each port has data, direction, output type and pull-up per pin.
// - lock bits 7-4 freeze output type and pull-up of port 1 pins 7-4.
// - route enable bit 0 with data bit 1 low routes pin 0 onto pin 1.
// - polarity bit 0 sets the active level of pin 0 for routing.
// - active pin 0 makes pin 1 drive 1 or float; inactive drives 0.
// - port 1 pins 0, 2, 3 as inputs feed power events.
// - reading an output pin returns the latch, not the pin.
// - writing an input pin only updates the latch.
// - write latches reset to all ones.
// - direction 0 input, 1 output; resets to 00h.
// - output type 0 open drain, 1 push-pull; resets to 00h.
// - pull-up bit 1 enables pull-up; resets to FFh.
module tpg_gpio (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [15:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // pins: three ports
    input  wire logic [23:0]       pin_in,
    output logic [23:0]            pin_out,
    output logic [23:0]            pin_oe_n,
    output logic [23:0]            pin_pull_en,
    // power event sources
    output logic                   power_on_req_src,
    output logic                   system_control_interrupt_src,
    output logic                   power_on_control_out_src
);
    // ======================================================================
    // configuration and bus state
    logic [23:0]           cfg_reg;
    logic [7:0]            route_reg;
    logic [7:0]            pol_reg;
    logic [7:0]            lock_reg;
    tpg_pkg::tpg_phase_e   phase_reg;
    logic [15:0]           addr_reg;
    logic [23:0]           pins_s;
    logic [23:0]           rd_s;
    tpg_pkg::tpg_port_s    port_cfg [3];
    tpg_pkg::tpg_pin_s     drive_next [3];

    logic        active12;
    logic        bank1;
    logic [15:0] base;
    logic        in_win;
    logic [2:0]  idx;
    logic        wr_go;
    logic [7:0]  wb;
    logic [3:0]  wr_p1;
    logic [3:0]  wr_p2;
    logic [3:0]  wr_p3;
    logic        wr_route;
    logic        wr_pol;
    logic        wr_lock;
    logic        wr_cfg;
    logic [7:0]  p1_lock;

    assign active12 = cfg_reg[`TPG_CFG_ACTIVE_BIT] & cfg_reg[`TPG_CFG_FUNC2_BIT];
    assign bank1    = cfg_reg[`TPG_CFG_BANK_BIT];
    assign base     = {cfg_reg[`TPG_BASE_HI_LSB +: 8], cfg_reg[`TPG_BASE_LO_LSB +: 8]};
    assign in_win   = (addr_reg[15:5] == base[15:5]);
    assign idx      = addr_reg[4:2];
    assign wr_go    = (phase_reg == tpg_pkg::TPG_WRITE);
    assign wb       = hwdata[7:0];
    assign p1_lock  = lock_reg & `TPG_LOCK_MASK;

    // ======================================================================
    // address phase capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= tpg_pkg::TPG_IDLE;
            addr_reg  <= 16'h0000;
        end else if (hready) begin
            if (hsel && htrans[1]) begin
                phase_reg <= hwrite ? tpg_pkg::TPG_WRITE : tpg_pkg::TPG_READ;
                addr_reg  <= haddr;
            end else begin
                phase_reg <= tpg_pkg::TPG_IDLE;
            end
        end
    end

    // ======================================================================
    // write decode
    always_comb begin
        wr_p1    = 4'h0;
        wr_p2    = 4'h0;
        wr_p3    = 4'h0;
        wr_route = 1'b0;
        wr_pol   = 1'b0;
        wr_lock  = 1'b0;
        wr_cfg   = wr_go && (addr_reg[7:0] == `TPG_ADDR_CFG) && (addr_reg[15:8] == 8'h00);
        if (wr_go && in_win && !wr_cfg) begin
            if (!bank1) begin
                if (idx[2]) begin
                    wr_p2[idx[1:0]] = 1'b1;
                end else begin
                    wr_p1[idx[1:0]] = 1'b1;
                end
            end else begin
                if (idx[2]) begin
                    wr_p3[idx[1:0]] = 1'b1;
                end else begin
                    case (idx)
                        `TPG_IDX_P1_ROUTE: wr_route = 1'b1;
                        `TPG_IDX_P1_POL:   wr_pol   = 1'b1;
                        `TPG_IDX_P1_LOCK:  wr_lock  = 1'b1;
                        default:           wr_route = 1'b0;
                    endcase
                end
            end
        end
    end

    // ======================================================================
    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= `TPG_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= hwdata[23:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            route_reg <= `TPG_RST_CTL;
            pol_reg   <= `TPG_RST_CTL;
        end else begin
            if (wr_route) begin
                route_reg <= wb;
            end
            if (wr_pol) begin
                pol_reg <= wb;
            end
        end
    end

    // lock bits are sticky until hard reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_reg <= `TPG_RST_CTL;
        end else if (wr_lock) begin
            lock_reg <= lock_reg | (wb & `TPG_LOCK_MASK);
        end
    end

    // ======================================================================
    // three ports
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            logic [3:0] wr;
            assign wr = (p == 0) ? wr_p1 : ((p == 1) ? wr_p2 : wr_p3);
            tpg_sync u_sync (
                .ref_clk  (ref_clk),
                .rst      (rst),
                .pin_raw  (pin_in[8*p +: 8]),
                .pin_sync (pins_s[8*p +: 8])
            );
            tpg_port u_port (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .wr_data   (wr[0]),
                .wr_dir    (wr[1]),
                .wr_otype  (wr[2]),
                .wr_pull   (wr[3]),
                .wdata     (wb),
                .lock_mask ((p == 0) ? p1_lock : 8'h00),
                .cfg       (port_cfg[p]),
                .rd_data   (rd_s[8*p +: 8]),
                .pin_level (pins_s[8*p +: 8])
            );
            always_comb begin
                logic [7:0] val;
                logic       en;
                val = port_cfg[p].data;
                en  = (p == 2) ? 1'b1 : active12;
                drive_next[p].pull_en = en ? port_cfg[p].pull : 8'h00;
                drive_next[p].oe_n    = 8'hFF;
                drive_next[p].out     = val;
                if (en) begin
                    for (int b = 0; b < 8; b++) begin
                        // open drain only sinks a zero
                        drive_next[p].oe_n[b] = !(port_cfg[p].dir[b] &&
                            (port_cfg[p].otype[b] || !val[b]));
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // routing of port 1 pin 0 onto pin 1 (the directions of pin 0 and pin 1 are not checked)
    logic route_on;
    logic src_active;
    assign route_on   = route_reg[0] && !port_cfg[0].data[1];
    assign src_active = pins_s[0] ^ pol_reg[0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out     <= 24'h000000;
            pin_oe_n    <= 24'hFFFFFF;
            pin_pull_en <= 24'h000000;
        end else begin
            pin_out     <= {drive_next[2].out, drive_next[1].out, drive_next[0].out};
            pin_oe_n    <= {drive_next[2].oe_n, drive_next[1].oe_n, drive_next[0].oe_n};
            pin_pull_en <= {drive_next[2].pull_en, drive_next[1].pull_en,
                            drive_next[0].pull_en};
            if (route_on && active12) begin
                pin_out[1]  <= src_active;
                pin_oe_n[1] <= !(!src_active || port_cfg[0].otype[1]);
            end
        end
    end

    // power event sources from input pins only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            power_on_req_src             <= 1'b0;
            system_control_interrupt_src <= 1'b0;
            power_on_control_out_src     <= 1'b0;
        end else begin
            power_on_req_src <= |(pins_s[3:0] & ~port_cfg[0].dir[3:0] & 4'hD);
            system_control_interrupt_src <= |(pins_s[3:0] & ~port_cfg[0].dir[3:0] & 4'hD);
            power_on_control_out_src <= pins_s[0] & ~port_cfg[0].dir[0];
        end
    end

    // ======================================================================
    // read data and response
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= 32'h00000000;
            if (haddr == {8'h00, `TPG_ADDR_CFG}) begin
                hrdata <= {8'h00, cfg_reg};
            end else if (haddr[15:5] == base[15:5]) begin
                if (!bank1) begin
                    case (haddr[3:2])
                        2'h0:    hrdata[7:0] <= haddr[4] ? rd_s[15:8] : rd_s[7:0];
                        2'h1:    hrdata[7:0] <= port_cfg[haddr[4] ? 1 : 0].dir;
                        2'h2:    hrdata[7:0] <= port_cfg[haddr[4] ? 1 : 0].otype;
                        default: hrdata[7:0] <= port_cfg[haddr[4] ? 1 : 0].pull;
                    endcase
                end else if (haddr[4]) begin
                    case (haddr[3:2])
                        2'h0:    hrdata[7:0] <= rd_s[23:16];
                        2'h1:    hrdata[7:0] <= port_cfg[2].dir;
                        2'h2:    hrdata[7:0] <= port_cfg[2].otype;
                        default: hrdata[7:0] <= port_cfg[2].pull;
                    endcase
                end else begin
                    case (haddr[3:2])
                        2'h0:    hrdata[7:0] <= route_reg;
                        2'h1:    hrdata[7:0] <= pol_reg;
                        2'h2:    hrdata[7:0] <= lock_reg;
                        default: hrdata[7:0] <= 8'h00;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ======================================================================
    // checks
    a_lock_holds: assert property (
        @(posedge ref_clk) disable iff (rst)
        lock_reg[7] |=> lock_reg[7])
        else $error("lock bit cleared");
    a_lock_otype: assert property (
        @(posedge ref_clk) disable iff (rst)
        lock_reg[4] |=> $stable(port_cfg[0].otype[4]))
        else $error("locked otype moved");
    a_lock_pull: assert property (
        @(posedge ref_clk) disable iff (rst)
        lock_reg[7] |=> $stable(port_cfg[0].pull[7]))
        else $error("locked pull-up moved");
    a_route_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        (route_on && active12 && !src_active) |=> (!pin_oe_n[1] && !pin_out[1]))
        else $error("route low not driven");
    a_port_off: assert property (
        @(posedge ref_clk) disable iff (rst)
        !active12 |=> (pin_oe_n[15:0] == 16'hFFFF))
        else $error("inactive port drives");
    a_bank1_safe: assert property (
        @(posedge ref_clk) disable iff (rst)
        bank1 |-> (wr_p1 == 4'h0 && wr_p2 == 4'h0))
        else $error("bank 1 wrote bank 0");
    a_bank0_safe: assert property (
        @(posedge ref_clk) disable iff (rst)
        !bank1 |-> (wr_p3 == 4'h0 && !wr_lock))
        else $error("bank 0 wrote bank 1");
    a_read_latch: assert property (
        @(posedge ref_clk) disable iff (rst)
        port_cfg[0].dir[2] |-> (rd_s[2] == port_cfg[0].data[2]))
        else $error("out read pin");
    a_latch_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_p2[0] |=> (port_cfg[1].data == $past(wb)))
        else $error("latch not written");
    a_power_on_control_out_src: assert property (
        @(posedge ref_clk) disable iff (rst)
        port_cfg[0].dir[0] |=> !power_on_control_out_src)
        else $error("output pin fed event");

    c_route: cover property (@(posedge ref_clk) route_on && active12);
    c_lock: cover property (@(posedge ref_clk) wr_lock);
    c_p3_write: cover property (@(posedge ref_clk) wr_p3[0]);
    c_p2_latch: cover property (@(posedge ref_clk) wr_p2[0]);
    c_power_src: cover property (@(posedge ref_clk) power_on_req_src);
endmodule // tpg_gpio

`default_nettype wire

/* File: hdl/tpg_cfg.svh */
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

// ==========================================================================
// register word indexes (byte address = index * 4)
`define TPG_IDX_P1_DATA     3'h0
`define TPG_IDX_P1_DIR      3'h1
`define TPG_IDX_P1_OTYPE    3'h2
`define TPG_IDX_P1_PULL     3'h3
`define TPG_IDX_P2_DATA     3'h4
`define TPG_IDX_P2_DIR      3'h5
`define TPG_IDX_P2_OTYPE    3'h6
`define TPG_IDX_P2_PULL     3'h7
// bank 1
`define TPG_IDX_P1_ROUTE    3'h0
`define TPG_IDX_P1_POL      3'h1
`define TPG_IDX_P1_LOCK     3'h2
`define TPG_IDX_P3_DATA     3'h4
`define TPG_IDX_P3_DIR      3'h5
`define TPG_IDX_P3_OTYPE    3'h6
`define TPG_IDX_P3_PULL     3'h7

// ==========================================================================
// configuration word at byte 0x40 (outside the 8-word window)
`define TPG_ADDR_CFG        8'h40
`define TPG_CFG_ACTIVE_BIT  0
`define TPG_CFG_FUNC2_BIT   1
`define TPG_CFG_BANK_BIT    7
`define TPG_BASE_LO_LSB     8
`define TPG_BASE_HI_LSB     16
`define TPG_CFG_RESET       24'h000000

// ==========================================================================
// reset values
`define TPG_RST_DATA        8'hFF
`define TPG_RST_DIR         8'h00
`define TPG_RST_OTYPE       8'h00
`define TPG_RST_PULL        8'hFF
`define TPG_RST_CTL         8'h00
`define TPG_LOCK_MASK       8'hF0

`endif

/* File: hdl/tpg_pkg.sv */
package tpg_pkg;

    // ======================================================================
    // per-port setting group
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] otype;
        logic [7:0] pull;
    } tpg_port_s;

    // ======================================================================
    // pin drive group: out value, enable (low = drive), pull-up
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull_en;
    } tpg_pin_s;

    typedef enum logic [1:0] {
        TPG_IDLE,
        TPG_WRITE,
        TPG_READ
    } tpg_phase_e;

endpackage

/* File: hdl/tpg_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module tpg_sync (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // pins
    input  wire logic [7:0] pin_raw,
    output var  logic [7:0] pin_sync
);
    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [7:0] s3_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // idle level of a pulled-up pin, so no false edge follows reset
            s1_reg <= 8'hFF;
            s2_reg <= 8'hFF;
            s3_reg <= 8'hFF;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    pin_sync[i] <= 1'b1;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    pin_sync[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
endmodule // tpg_sync

`default_nettype wire

/* File: hdl/tpg_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"

// ==========================================================================
// one eight-pin port: latch, direction, output type, pull-up
module tpg_port (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // register writes
    input  wire logic             wr_data,
    input  wire logic             wr_dir,
    input  wire logic             wr_otype,
    input  wire logic             wr_pull,
    input  wire logic [7:0]       wdata,
    input  wire logic [7:0]       lock_mask,
    // state
    output var  tpg_pkg::tpg_port_s cfg,
    output var  logic [7:0]       rd_data,
    input  wire logic [7:0]       pin_level
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.data <= `TPG_RST_DATA;
        end else if (wr_data) begin
            cfg.data <= wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.dir <= `TPG_RST_DIR;
        end else if (wr_dir) begin
            cfg.dir <= wdata;
        end
    end

    // locked bits keep their value
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.otype <= `TPG_RST_OTYPE;
        end else if (wr_otype) begin
            cfg.otype <= (wdata & ~lock_mask) | (cfg.otype & lock_mask);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.pull <= `TPG_RST_PULL;
        end else if (wr_pull) begin
            cfg.pull <= (wdata & ~lock_mask) | (cfg.pull & lock_mask);
        end
    end

    // outputs read the latch, inputs the pin
    assign rd_data = (cfg.dir & cfg.data) | (~cfg.dir & pin_level);
endmodule // tpg_port

`default_nettype wire

/* File: verification/tpg_board.sv */
`timescale 1ns/1ns
`default_nettype none

// ====================
// board side of the 24 pins: resolves each wire from all its drivers
module tpg_board (
    // clock
    input  wire logic        ref_clk,
    // device drive
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe_n,
    input  wire logic [23:0] pin_pull_en,
    // board drivers
    input  wire logic [23:0] ext_val,
    input  wire logic [23:0] ext_en,
    // wire level
    output var  logic [23:0] pin_level
);
    logic [23:0] noise_reg = 24'hA5A5A5;

    // a floating wire toggles so a stale level never passes for a read
    always_ff @(posedge ref_clk) noise_reg <= ~noise_reg;

    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
            else if (ext_en[i]) pin_level[i] = ext_val[i];
            else if (pin_pull_en[i]) pin_level[i] = 1'b1;
            else pin_level[i] = noise_reg[i];
        end
    end
endmodule // tpg_board

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"

module testbench;
    typedef struct packed {
        logic       bank;
        logic [2:0] idx;
        logic       wr;
        logic [7:0] wd;
        logic [7:0] exp;
    } tpg_row_s;

    // ====================
    // signals
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [23:0] pin_in;
    logic [23:0] pin_out;
    logic [23:0] pin_oe_n;
    logic [23:0] pin_pull_en;
    logic [23:0] ext_val = 24'h000000;
    logic [23:0] ext_en = 24'h000000;
    logic        por_src;
    logic        sci_src;
    logic        onc_src;
    logic [15:0] base = 16'h0100;
    logic [31:0] rd;
    int          num_errors = 0;
    int          checked = 0;
    tpg_row_s    rows [14] = '{
        '{1'b0, `TPG_IDX_P1_DIR, 1'b0, 8'h00, 8'h00},
        '{1'b0, `TPG_IDX_P1_OTYPE, 1'b0, 8'h00, 8'h00},
        '{1'b0, `TPG_IDX_P1_PULL, 1'b0, 8'h00, 8'hFF},
        '{1'b0, `TPG_IDX_P2_PULL, 1'b0, 8'h00, 8'hFF},
        '{1'b1, `TPG_IDX_P1_ROUTE, 1'b0, 8'h00, 8'h00},
        '{1'b1, `TPG_IDX_P1_POL, 1'b0, 8'h00, 8'h00},
        '{1'b1, `TPG_IDX_P1_LOCK, 1'b0, 8'h00, 8'h00},
        '{1'b1, `TPG_IDX_P3_DIR, 1'b0, 8'h00, 8'h00},
        '{1'b1, `TPG_IDX_P3_PULL, 1'b0, 8'h00, 8'hFF},
        '{1'b0, `TPG_IDX_P2_OTYPE, 1'b1, 8'h5A, 8'h5A},
        '{1'b0, `TPG_IDX_P2_DATA, 1'b1, 8'hC3, 8'hFF},
        '{1'b1, `TPG_IDX_P3_OTYPE, 1'b1, 8'h3C, 8'h3C},
        '{1'b0, `TPG_IDX_P2_OTYPE, 1'b0, 8'h00, 8'h5A},
        '{1'b1, 3'h3, 1'b1, 8'h77, 8'h00}
    };

    always #25 ref_clk = ~ref_clk;

    tpg_gpio dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_en(pin_pull_en), .power_on_req_src(por_src),
        .system_control_interrupt_src(sci_src), .power_on_control_out_src(onc_src));

    tpg_board board_u (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_en(pin_pull_en), .ext_val(ext_val), .ext_en(ext_en),
        .pin_level(pin_in));

    // ====================
    // tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // ready and read data are taken at the rising edge that ends the phase
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                tally_and_finish();
            end
            @(posedge ref_clk);
        end
        rd = hrdata;
    endtask

    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] v);
        xfer(1'b1, base + {11'h000, idx, 2'h0}, {24'h000000, v});
    endtask

    task automatic rchk(input string what, input logic [2:0] idx, input logic [7:0] exp);
        xfer(1'b0, base + {11'h000, idx, 2'h0}, 32'h00000000);
        check(what, rd, {24'h000000, exp});
    endtask

    task automatic cfg(input logic bank, input logic act, input logic fe);
        xfer(1'b1, {8'h00, `TPG_ADDR_CFG}, {8'h00, base, bank, 5'h00, fe, act});
    endtask

    // covers the synchroniser delay of pin inputs
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic drive(input logic [23:0] v, input logic [23:0] en);
        @(posedge ref_clk);
        ext_val <= v;
        ext_en  <= en;
        settle();
    endtask

    // ====================
    // sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            cfg(rows[i].bank, 1'b1, 1'b1);
            if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
            rchk("row", rows[i].idx, rows[i].exp);
        end
        $display("test table done");
        cfg(1'b0, 1'b1, 1'b1);
        wr(`TPG_IDX_P1_DATA, 8'h5A);
        drive(24'h000000, 24'h0000FF);
        check("p1 oe_n", pin_oe_n[7:0], 8'hFF);
        rchk("p1 in", `TPG_IDX_P1_DATA, 8'h00);
        wr(`TPG_IDX_P1_PULL, 8'h00);
        wr(`TPG_IDX_P1_DIR, 8'hFF);
        settle();
        check("p1 oe_n", pin_oe_n[7:0], 8'h5A);
        rchk("p1 latch", `TPG_IDX_P1_DATA, 8'h5A);
        drive(24'h000000, 24'h000000);
        wr(`TPG_IDX_P1_OTYPE, 8'hFF);
        settle();
        check("p1 oe_n", pin_oe_n[7:0], 8'h00);
        check("p1 out", pin_out[7:0], 8'h5A);
        check("p1 pull", pin_pull_en[7:0], 8'h00);
        $display("test latch done");
        drive(24'h960000, 24'hFF0000);
        cfg(1'b1, 1'b0, 1'b0);
        rchk("p3 in", `TPG_IDX_P3_DATA, 8'h96);
        settle();
        check("p1 off", pin_oe_n[7:0], 8'hFF);
        cfg(1'b1, 1'b1, 1'b0);
        settle();
        check("p1 off", pin_oe_n[7:0], 8'hFF);
        cfg(1'b1, 1'b1, 1'b1);
        settle();
        check("p1 on", pin_oe_n[7:0], 8'h00);
        $display("test activation done");
        wr(`TPG_IDX_P1_LOCK, 8'hF0);
        wr(`TPG_IDX_P1_LOCK, 8'h00);
        rchk("lock", `TPG_IDX_P1_LOCK, 8'hF0);
        cfg(1'b0, 1'b1, 1'b1);
        wr(`TPG_IDX_P1_OTYPE, 8'h02);
        rchk("otype", `TPG_IDX_P1_OTYPE, 8'hF2);
        wr(`TPG_IDX_P1_PULL, 8'hFF);
        rchk("pull", `TPG_IDX_P1_PULL, 8'h0F);
        $display("test lock done");
        wr(`TPG_IDX_P1_DIR, 8'h02);
        wr(`TPG_IDX_P1_DATA, 8'h00);
        cfg(1'b1, 1'b1, 1'b1);
        wr(`TPG_IDX_P1_ROUTE, 8'h01);
        drive(24'h000001, 24'h000001);
        check("pin1", {pin_out[1], pin_oe_n[1]}, 2'b10);
        drive(24'h000000, 24'h000001);
        check("pin1", {pin_out[1], pin_oe_n[1]}, 2'b00);
        wr(`TPG_IDX_P1_POL, 8'h01);
        settle();
        check("pin1", {pin_out[1], pin_oe_n[1]}, 2'b10);
        drive(24'h000001, 24'h000001);
        check("pin1", {pin_out[1], pin_oe_n[1]}, 2'b00);
        cfg(1'b0, 1'b1, 1'b1);
        wr(`TPG_IDX_P1_DATA, 8'h02);
        settle();
        check("pin1", {pin_out[1], pin_oe_n[1]}, 2'b10);
        $display("test routing done");
        wr(`TPG_IDX_P1_DIR, 8'h00);
        drive(24'h000000, 24'h0000FF);
        check("power", {por_src, sci_src, onc_src}, 3'b000);
        drive(24'h000004, 24'h0000FF);
        check("power", {por_src, sci_src, onc_src}, 3'b110);
        drive(24'h000001, 24'h0000FF);
        check("power", {por_src, sci_src, onc_src}, 3'b111);
        wr(`TPG_IDX_P1_DATA, 8'h0D);
        wr(`TPG_IDX_P1_DIR, 8'h0D);
        drive(24'h00000D, 24'h0000FF);
        check("power", {por_src, sci_src, onc_src}, 3'b000);
        $display("test power done");
        base = 16'h0200;
        cfg(1'b1, 1'b1, 1'b1);
        rchk("moved", `TPG_IDX_P3_OTYPE, 8'h3C);
        xfer(1'b0, 16'h0118, 32'h00000000);
        check("old base", rd, 32'h00000000);
        check("hresp", {31'h00000000, hresp}, 32'h00000000);
        $display("test base done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        base = 16'h0100;
        drive(24'h000000, 24'h000000);
        cfg(1'b1, 1'b1, 1'b1);
        rchk("lock rst", `TPG_IDX_P1_LOCK, 8'h00);
        cfg(1'b0, 1'b1, 1'b1);
        wr(`TPG_IDX_P1_DIR, 8'hFF);
        rchk("latch rst", `TPG_IDX_P1_DATA, 8'hFF);
        settle();
        check("p1 oe_n", pin_oe_n[7:0], 8'hFF);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
